/* File: design/dpwm_unit.sv */
// dual pulse-width generator with fixed output channels
// assumes prescale and duty are written by logic on clk_sys as
// one-cycle strobes; clk_sys serves as the divider's base tick
// limitation: there is no separate 48 MHz clock; the prescale divides
// clk_sys, so real periods scale with the clk_sys rate
// trade-off: settings are double-buffered per generator so a cycle
// never mixes an old duty with a new prescale
// out-of-range writes are dropped whole, not clamped, and only flagged
//
// Function
// - two independent generators, fixed to output channels 3 and 7
// - tick comes from the base clock divided by the prescale value
// - one output cycle is exactly 1000 divided ticks
// - prescale settings from 2 to 65535 inclusive are accepted
// - duty zero keeps the output off the whole cycle
// - duty 1 to 999 gives that many on-ticks per cycle
// - duty 1000 keeps the output on without an off phase
// - output one means channel switched on, zero switched off
`timescale 1ns/100ps
`default_nettype none
module dpwm_unit (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [dpwm_pkg::NUM_GEN-1:0] cfgWrite,
	input wire logic [dpwm_pkg::PRESC_W-1:0] cfgPrescFirst,
	input wire logic [dpwm_pkg::DUTY_W-1:0] cfgDutyFirst,
	input wire logic [dpwm_pkg::PRESC_W-1:0] cfgPrescSecond,
	input wire logic [dpwm_pkg::DUTY_W-1:0] cfgDutySecond,
	input wire logic [dpwm_pkg::NUM_GEN-1:0] chanFuncSel,
	output logic pwmOutCh3,
	output logic pwmOutCh7,
	output logic [dpwm_pkg::NUM_GEN-1:0] genActive,
	output logic [dpwm_pkg::NUM_GEN-1:0] cfgRejected
);

	localparam int N = dpwm_pkg::NUM_GEN;

	typedef struct packed {
		// live settings of the running cycle
		logic [N-1:0] en;
		logic [N-1:0][dpwm_pkg::PRESC_W-1:0] presc;
		logic [N-1:0][dpwm_pkg::DUTY_W-1:0] duty;
		// settings waiting for the next cycle boundary
		logic [N-1:0] pendValid;
		logic [N-1:0][dpwm_pkg::PRESC_W-1:0] pendPresc;
		logic [N-1:0][dpwm_pkg::DUTY_W-1:0] pendDuty;
		// divider, position within the cycle, output level and reject flag
		logic [N-1:0][dpwm_pkg::PRESC_W-1:0] divCnt;
		logic [N-1:0][dpwm_pkg::TICK_W-1:0] tick;
		logic [N-1:0] out;
		logic [N-1:0] reject;
	} dpwm_state_t;

	function automatic logic dpwmCfgOk(
		input logic [dpwm_pkg::PRESC_W-1:0] p,
		input logic [dpwm_pkg::DUTY_W-1:0] d
	);
		dpwmCfgOk = (p >= dpwm_pkg::PRESC_MIN) &&
			(p <= dpwm_pkg::PRESC_MAX) && (d <= dpwm_pkg::DUTY_FULL);
	endfunction

	// last base cycle of one divided tick
	// prescale never below two here, so the minus one cannot wrap
	function automatic logic dpwmDivEnd(
		input logic [dpwm_pkg::PRESC_W-1:0] cnt,
		input logic [dpwm_pkg::PRESC_W-1:0] presc
	);
		dpwmDivEnd = (cnt == presc - dpwm_pkg::PRESC_W'(1));
	endfunction

	function automatic logic [dpwm_pkg::PRESC_W-1:0] dpwmDivNext(
		input logic [dpwm_pkg::PRESC_W-1:0] cnt
	);
		dpwmDivNext = cnt + dpwm_pkg::PRESC_W'(1);
	endfunction

	function automatic logic [dpwm_pkg::TICK_W-1:0] dpwmTickNext(
		input logic [dpwm_pkg::TICK_W-1:0] tick
	);
		dpwmTickNext = tick + dpwm_pkg::TICK_W'(1);
	endfunction

	// level of the output for a duty and a tick position
	// end values decoded apart so no off or on sliver appears
	function automatic logic dpwmOnLevel(
		input logic [dpwm_pkg::DUTY_W-1:0] duty,
		input logic [dpwm_pkg::TICK_W-1:0] tick
	);
		if (duty == dpwm_pkg::DUTY_OFF) begin
			// never on, not even at tick zero
			dpwmOnLevel = 1'b0;
		end else if (duty == dpwm_pkg::DUTY_FULL) begin
			// tick stops at 999, so the compare alone would also hold full on
			dpwmOnLevel = 1'b1;
		end else begin
			// on for the first duty ticks of the cycle
			dpwmOnLevel = {1'b0, tick} < duty;
		end
	endfunction

	logic [1:0] rstSync_q;
	logic rstN;
	dpwm_state_t state_q;
	dpwm_state_t state_d;
	logic [N-1:0][dpwm_pkg::PRESC_W-1:0] inPresc;
	logic [N-1:0][dpwm_pkg::DUTY_W-1:0] inDuty;
	logic [N-1:0] divEnd;
	logic [N-1:0] cycEnd;
	logic [N-1:0] wrOk;
	logic [N-1:0] wrBad;

	// reset released through two flops to avoid a ragged release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];

	// fixed mapping of generator to channel
	assign inPresc[0] = cfgPrescFirst;
	assign inDuty[0] = cfgDutyFirst;
	assign inPresc[1] = cfgPrescSecond;
	assign inDuty[1] = cfgDutySecond;

	// strobes come from registered state only
	// so a late write cannot shorten the running tick
	for (genvar g = 0; g < N; g++) begin : gen_strobe
		assign divEnd[g] = state_q.en[g] &&
			dpwmDivEnd(state_q.divCnt[g], state_q.presc[g]);
		assign cycEnd[g] = divEnd[g] &&
			(state_q.tick[g] == dpwm_pkg::TICK_LAST);
		// range check on the incoming pair
		assign wrOk[g] = cfgWrite[g] &&
			dpwmCfgOk(inPresc[g], inDuty[g]);
		assign wrBad[g] = cfgWrite[g] && !wrOk[g];
	end

	always_comb begin
		state_d = state_q;
		for (int i = 0; i < N; i++) begin
			state_d.reject[i] = 1'b0;
			if (state_q.en[i]) begin
				if (divEnd[i]) begin
					state_d.divCnt[i] = '0;
				end else begin
					state_d.divCnt[i] = dpwmDivNext(state_q.divCnt[i]);
				end
				if (cycEnd[i]) begin
					state_d.tick[i] = '0;
				end else if (divEnd[i]) begin
					state_d.tick[i] = dpwmTickNext(state_q.tick[i]);
				end
				// new setting only at cycle boundary
				if (cycEnd[i] && state_q.pendValid[i]) begin
					state_d.presc[i] = state_q.pendPresc[i];
					state_d.duty[i] = state_q.pendDuty[i];
					state_d.pendValid[i] = 1'b0;
				end
			end else if (state_q.pendValid[i]) begin
				// first valid setting starts the generator
				state_d.en[i] = 1'b1;
				state_d.presc[i] = state_q.pendPresc[i];
				state_d.duty[i] = state_q.pendDuty[i];
				state_d.pendValid[i] = 1'b0;
				// counters restart so the first cycle is whole
				state_d.divCnt[i] = '0;
				state_d.tick[i] = '0;
			end
			// newest write wins; a write at the boundary waits one cycle
			if (wrOk[i]) begin
				state_d.pendValid[i] = 1'b1;
				state_d.pendPresc[i] = inPresc[i];
				state_d.pendDuty[i] = inDuty[i];
			end
			// out-of-range pair is dropped, only flagged
			if (wrBad[i]) begin
				state_d.reject[i] = 1'b1;
			end
			// on while tick below duty
			// counting goes on while the channel is not selected
			state_d.out[i] = state_d.en[i] && chanFuncSel[i] &&
				dpwmOnLevel(state_d.duty[i], state_d.tick[i]);
		end
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// generator zero on channel three, one on channel seven
	// the mapping is wired, never a setting
	// high drives the channel on
	assign pwmOutCh3 = state_q.out[0];
	assign pwmOutCh7 = state_q.out[1];
	assign genActive = state_q.en;
	assign cfgRejected = state_q.reject;

endmodule
`default_nettype wire

/* File: pkg/dpwm_pkg.sv */
// constants for the dual pulse-width output unit
// assumes one system clock; configuration arrives from same-clock logic
package dpwm_pkg;
	localparam int NUM_GEN = 2;
	localparam int PRESC_W = 16;
	localparam int DUTY_W = 11;
	localparam int TICK_W = 10;
	localparam logic [PRESC_W-1:0] PRESC_MIN = 16'h0002;
	localparam logic [PRESC_W-1:0] PRESC_MAX = 16'hffff;
	localparam logic [PRESC_W-1:0] PRESC_RESET = 16'h0000;
	localparam logic [DUTY_W-1:0] DUTY_OFF = 11'h000;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 11'h3e8;
	localparam logic [TICK_W-1:0] TICK_LAST = 10'h3e7;
	localparam int CHAN_FIRST = 3;
	localparam int CHAN_SECOND = 7;
	localparam int BASE_CLK_MHZ = 48;
endpackage

/* File: tb/dpwm_unit_asserts.sv */
// port checker for dpwm_unit
// assumes a bind from the bench
`timescale 1ns/100ps
`default_nettype none
module dpwm_unit_asserts (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [1:0] cfgWrite,
	input wire logic [15:0] cfgPrescFirst,
	input wire logic [10:0] cfgDutyFirst,
	input wire logic [1:0] chanFuncSel,
	input wire logic pwmOutCh3,
	input wire logic pwmOutCh7,
	input wire logic [1:0] genActive,
	input wire logic [1:0] cfgRejected
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	chk_reject_once: assert property (!cfgWrite[0] |=> !cfgRejected[0])
		else $error("long reject");
	chk_low_presc: assert property (cfgWrite[0] && cfgPrescFirst < 2 |=>
		cfgRejected[0]) else $error("low prescale taken");
	chk_big_duty: assert property (cfgWrite[0] && cfgDutyFirst > 1000 |=>
		cfgRejected[0]) else $error("big duty taken");
	chk_good_cfg: assert property (cfgWrite[0] && cfgPrescFirst > 1 &&
		cfgDutyFirst < 1001 |=> !cfgRejected[0]) else $error("good cfg refused");
	chk_idle_first: assert property (!genActive[0] |-> !pwmOutCh3)
		else $error("idle first on");
	chk_idle_second: assert property (!genActive[1] |-> !pwmOutCh7)
		else $error("idle second on");
	chk_stay_active: assert property (genActive[0] |=> genActive[0])
		else $error("active dropped");
	chk_func_gate: assert property (!chanFuncSel[1] [*2] |-> !pwmOutCh7)
		else $error("gated output on");
endmodule
`default_nettype wire

/* File: tb/dpwm_actuator.sv */
// load on one output channel, counts on-cycles
// assumes drive is a level on clk_sys
`timescale 1ns/100ps
`default_nettype none
module dpwm_actuator (
	input wire logic clk_sys,
	input wire logic drive,
	output logic [31:0] onCnt
);
	initial onCnt = 0;
	always @(posedge clk_sys) if (drive === 1'b1) onCnt <= onCnt + 1;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for dpwm_unit
// assumes actuator and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys = 0, resetn = 0;
	logic [1:0] cfgWrite = 0, chanFuncSel = 0, genActive, cfgRejected;
	logic [15:0] pA = 0;
	logic [10:0] dA = 0, dB = 0;
	logic pwmOutCh3, pwmOutCh7;
	logic [31:0] c3, c7, a, b, seed = 16, cyc = 0;
	int n_errors = 0, n_checks = 0;
	dpwm_unit dut (.clk_sys, .resetn, .cfgWrite, .cfgPrescFirst(pA),
		.cfgDutyFirst(dA), .cfgPrescSecond(pA), .cfgDutySecond(dB),
		.chanFuncSel, .pwmOutCh3, .pwmOutCh7, .genActive, .cfgRejected);
	dpwm_actuator ld3 (.clk_sys, .drive(pwmOutCh3), .onCnt(c3));
	dpwm_actuator ld7 (.clk_sys, .drive(pwmOutCh7), .onCnt(c7));
	initial forever #5 clk_sys = ~clk_sys;
	task chk(logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %0t: saw %0d want %0d", $time, s, e);
		end
	endtask
	function automatic logic [31:0] nextRand(logic [31:0] s);
		logic [31:0] r;
		r = s ^ (s << 13);
		r = r ^ (r >> 17);
		nextRand = r ^ (r << 5);
	endfunction
	function automatic logic [31:0] expOn(logic [15:0] p, logic [10:0] d,
		logic f);
		expOn = f ? 32'(d) * 32'(p) : 32'h0;
	endfunction
	task wr(logic [15:0] p, logic [10:0] d);
		@(posedge clk_sys);
		{pA, dA, dB, cfgWrite} <= {p, d, 11'd1000 - d, 2'h3};
		@(posedge clk_sys);
		cfgWrite <= 2'h0;
		#1 chk(cfgRejected, (p < 2 || d > 1000) ? 3 : 0);
	endtask
	// second channel gets the complement duty, same prescale
	task test(logic [15:0] p, logic [10:0] d, logic [1:0] f);
		wr(p, d);
		chanFuncSel <= f;
		repeat (5000) @(posedge clk_sys);
		{a, b} = {c3, c7};
		repeat (1000 * p) @(posedge clk_sys);
		chk(c3 - a, expOn(p, d, f[0]));
		chk(c7 - b, expOn(p, 11'd1000 - d, f[1]));
		$display("done p=%0d d=%0d", p, d);
	endtask
	task results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) if (++cyc == 100000) begin
		n_errors++;
		results;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1;
		repeat (3) @(posedge clk_sys);
		chk(genActive, 0);
		// tiny periods only to bound run time
		test(2, 0, 3);
		test(3, 1000, 3);
		test(2, 999, 1);
		wr(1, 5);
		wr(2, 1001);
		chk(genActive, 3);
		for (int i = 0; i < 3; i++) begin
			seed = nextRand(seed);
			test(2 + seed[1:0], seed % 1001, 3);
		end
		results;
	end
endmodule
bind dpwm_unit dpwm_unit_asserts chk_i (.clk_sys(clk_sys), .resetn(resetn),
	.cfgWrite(cfgWrite), .cfgPrescFirst(cfgPrescFirst),
	.cfgDutyFirst(cfgDutyFirst), .chanFuncSel(chanFuncSel),
	.pwmOutCh3(pwmOutCh3), .pwmOutCh7(pwmOutCh7), .genActive(genActive),
	.cfgRejected(cfgRejected));
`default_nettype wire
